// file: src/pdl_pkg.sv
// Purpose: constants shared by the device status and link capability register block
// Assumes: configuration offsets are byte addresses inside one 4 KB function space
// Notes: every offset, field position, reset value and fixed field value lives here
package pdl_pkg;

  // configuration address width and register byte offsets
  localparam int CFG_AW = 12;
  localparam logic [11:0] DEV_CTRL_OFF = 12'h078;
  localparam logic [11:0] DEV_STAT_OFF = 12'h07A;
  localparam logic [11:0] LINK_CAP_OFF = 12'h07C;

  // device control word, low half of the dword at 078h
  localparam int CTRL_CORRECTABLE_EN_BIT = 0;
  localparam int CTRL_NONFATAL_EN_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'h0;

  // device status word, upper half of the dword at 078h
  localparam int STAT_LSB = 16;
  localparam int STAT_CORRECTABLE_BIT = 0;
  localparam int STAT_NONFATAL_BIT = 1;
  localparam int STAT_FATAL_BIT = 2;
  localparam int STAT_UNSUPPORTED_BIT = 3;
  localparam int STAT_AUX_POWER_BIT = 4;
  localparam int STAT_PENDING_BIT = 5;
  localparam int STAT_NUM_FLAGS = 4;
  localparam int STAT_CTRL_BYTE = 0;
  localparam int STAT_FLAG_BYTE = 2;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // link capabilities field values
  localparam logic [7:0] LCAP_PORT_NUM = 8'h00;
  localparam logic [1:0] LCAP_RSVD = 2'h0;
  localparam logic LCAP_BW_NOTIFY = 1'h0;
  localparam logic LCAP_DL_ACTIVE = 1'h0;
  localparam logic LCAP_SURPRISE_DOWN = 1'h0;
  localparam logic LCAP_CLOCK_PM = 1'h1;
  localparam logic [2:0] LCAP_L0S_COMMON = 3'h3;
  localparam logic [2:0] LCAP_L0S_ASYNC = 3'h4;
  localparam logic [1:0] LCAP_ASPM = 2'h3;
  localparam logic [5:0] LCAP_MAX_WIDTH = 6'h01;
  localparam logic [3:0] LCAP_MAX_SPEED = 4'h1;

  // read data for an unmapped dword
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // non-posted requests the upstream side keeps in flight
  localparam int MAX_NP_DEF = 4;

endpackage : pdl_pkg

// file: src/pdl_sticky_flag.sv
// Purpose: one hardware-set, write-one-to-clear status flag
// Assumes: set and clr are single-cycle, synchronous to mclk
// Notes: a set in the same cycle as a clear keeps the flag set
`timescale 1ns/1ps
module pdl_sticky_flag (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic q
);

  typedef struct packed {
    logic flag;
  } pdl_flag_s;

  pdl_flag_s st;
  pdl_flag_s next_st;

  // set beats clear so an event landing on the clear cycle is not lost
  always_comb begin
    next_st = st;
    if (set) begin
      next_st.flag = 1'b1; // R11
    end else if (clr) begin
      next_st.flag = 1'b0; // R11
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.flag;

endmodule : pdl_sticky_flag

// file: src/pdl_np_tracker.sv
// Purpose: counts issued non-posted requests not yet completed
// Assumes: a completion never arrives for a request that was not issued
// Notes: saturates at both ends instead of wrapping
`timescale 1ns/1ps
module pdl_np_tracker #(
  parameter int MAX_NP = pdl_pkg::MAX_NP_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // request events
  input wire logic issue,
  input wire logic done,
  // state
  output logic pending
);

  localparam int CW = $clog2(MAX_NP + 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } pdl_np_s;

  pdl_np_s st;
  pdl_np_s next_st;

  // refuse a depth the counter cannot hold, before any logic is built
  if (MAX_NP < 1) begin : g_bad_max_np
    $error("pdl_np_tracker: MAX_NP must be at least 1");
  end

  // issue and done together leave the count unchanged
  always_comb begin
    next_st = st;
    if (issue && !done && (st.count != CW'(MAX_NP))) begin
      next_st.count = st.count + CW'(1);
    end else if (done && !issue && (st.count != '0)) begin
      next_st.count = st.count - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pending = (st.count != '0); // R5

endmodule : pdl_np_tracker

// file: src/pdl_cfg_regs.sv
// Purpose: device control low bits, device status and link capabilities in config space
// Assumes: config accesses are single-cycle strobes synchronous to mclk
// Notes: upper device control fields are not held here and read as zero
`timescale 1ns/1ps
// Operation
// R1 - nonfatal report enable set: nonfatal system error sends a nonfatal message upstream
// R2 - correctable report enable set: correctable system error sends a correctable message
// R3 - both report enables reset to zero and are software read/write
// R4 - device status bits 15 to 6 always read zero
// R5 - status bit 5 set while an issued non-posted request is uncompleted
// R6 - status bit 4 shows whether auxiliary power is present
// R7 - status bit 3 set when an unsupported request is received
// R8 - status bit 2 set when a fatal error is detected
// R9 - status bit 1 set when a nonfatal error is detected
// R10 - status bit 0 set when a correctable error is detected
// R11 - error flags stay set until software writes one; writing zero does nothing
// R12 - link port number field reads zero
// R13 - link capability bits 23 and 22 read zero
// R14 - bandwidth notify, link active and surprise down bits read zero
// R15 - clock power management bit reads one
// R16 - L1 exit field picks diagnostic upper or lower field by common clock
// R17 - L0s exit field reads 011b common clock, 100b asynchronous clock
// R18 - active state power management support reads 11b
// R19 - maximum link width reads one lane
// R20 - maximum link speed reads 1h, 2.5 Gb/s
module pdl_cfg_regs #(
  parameter int MAX_NP = pdl_pkg::MAX_NP_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // link setup from neighbouring registers
  input wire logic ccc_common,
  input wire logic [2:0] diag_l1_exit_upper_field,
  input wire logic [2:0] diag_l1_exit_lower_field,
  input wire logic aux_power_in,
  // device events, one-cycle pulses
  input wire logic np_req_issue,
  input wire logic np_req_done,
  input wire logic correctable_err_event,
  input wire logic nonfatal_err_event,
  input wire logic fatal_err_event,
  input wire logic unsupported_req_event,
  // upstream error messages, one-cycle pulses
  output logic err_cor_msg,
  output logic err_nonfatal_msg
);

  typedef struct packed {
    logic [31:0] rdata;
    logic rd_valid;
    logic cor_msg;
    logic nf_msg;
    logic correctable_report_en;
    logic nonfatal_report_en;
    logic aux_power_present;
  } pdl_regs_s;

  pdl_regs_s st;
  pdl_regs_s next_st;
  logic rst_meta;
  logic rst_n;
  logic request_outstanding;
  logic [pdl_pkg::STAT_NUM_FLAGS-1:0] flag_set;
  logic [pdl_pkg::STAT_NUM_FLAGS-1:0] flag_clr;
  logic [pdl_pkg::STAT_NUM_FLAGS-1:0] flag_q;
  logic hit_ctrl;
  logic hit_lcap;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic [31:0] lcap_word;

  // reset released through two flops; asserted at once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // dword decode; 07Ah shares the dword at 078h and is picked by byte lanes
  assign hit_ctrl = (cfg_addr[11:2] == pdl_pkg::DEV_CTRL_OFF[11:2]);
  assign hit_lcap = (cfg_addr[11:2] == pdl_pkg::LINK_CAP_OFF[11:2]);

  // hardware sets of the four error flags
  assign flag_set[pdl_pkg::STAT_CORRECTABLE_BIT] = correctable_err_event; // R10
  assign flag_set[pdl_pkg::STAT_NONFATAL_BIT] = nonfatal_err_event; // R9
  assign flag_set[pdl_pkg::STAT_FATAL_BIT] = fatal_err_event; // R8
  assign flag_set[pdl_pkg::STAT_UNSUPPORTED_BIT] = unsupported_req_event; // R7

  // write-one-to-clear through the status byte lane only
  generate
    for (genvar i = 0; i < pdl_pkg::STAT_NUM_FLAGS; i++) begin : g_flag
      assign flag_clr[i] = cfg_wr && hit_ctrl && cfg_be[pdl_pkg::STAT_FLAG_BYTE]
        && cfg_wdata[pdl_pkg::STAT_LSB + i]; // R11
      pdl_sticky_flag u_flag (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(flag_set[i]),
        .clr(flag_clr[i]),
        .q(flag_q[i])
      );
    end
  endgenerate

  // outstanding non-posted requests
  pdl_np_tracker #(
    .MAX_NP(MAX_NP)
  ) u_np (
    .mclk(mclk),
    .rst_n(rst_n),
    .issue(np_req_issue),
    .done(np_req_done),
    .pending(request_outstanding)
  );

  // device control: only the two report enables live here
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[pdl_pkg::CTRL_CORRECTABLE_EN_BIT] = st.correctable_report_en;
    ctrl_word[pdl_pkg::CTRL_NONFATAL_EN_BIT] = st.nonfatal_report_en;
  end

  // device status; bits 15:6 stay at the zero reset value
  always_comb begin
    stat_word = pdl_pkg::STAT_RESET; // R4
    stat_word[pdl_pkg::STAT_NUM_FLAGS-1:0] = flag_q;
    stat_word[pdl_pkg::STAT_AUX_POWER_BIT] = st.aux_power_present; // R6
    stat_word[pdl_pkg::STAT_PENDING_BIT] = request_outstanding; // R5
  end

  // link capabilities; only the exit latencies follow the clock mode
  assign lcap_word = {
    pdl_pkg::LCAP_PORT_NUM, // R12
    pdl_pkg::LCAP_RSVD, // R13
    pdl_pkg::LCAP_BW_NOTIFY, // R14
    pdl_pkg::LCAP_DL_ACTIVE, // R14
    pdl_pkg::LCAP_SURPRISE_DOWN, // R14
    pdl_pkg::LCAP_CLOCK_PM, // R15
    (ccc_common ? diag_l1_exit_upper_field : diag_l1_exit_lower_field), // R16
    (ccc_common ? pdl_pkg::LCAP_L0S_COMMON : pdl_pkg::LCAP_L0S_ASYNC), // R17
    pdl_pkg::LCAP_ASPM, // R18
    pdl_pkg::LCAP_MAX_WIDTH, // R19
    pdl_pkg::LCAP_MAX_SPEED // R20
  };

  // next state: register writes, read data, message pulses
  always_comb begin
    next_st = st;
    next_st.rd_valid = cfg_rd;
    next_st.aux_power_present = aux_power_in; // R6
    if (cfg_rd) begin
      if (hit_ctrl) begin
        next_st.rdata = {stat_word, ctrl_word};
      end else if (hit_lcap) begin
        next_st.rdata = lcap_word;
      end else begin
        next_st.rdata = pdl_pkg::RD_UNMAPPED;
      end
    end
    if (cfg_wr && hit_ctrl && cfg_be[pdl_pkg::STAT_CTRL_BYTE]) begin
      next_st.correctable_report_en = cfg_wdata[pdl_pkg::CTRL_CORRECTABLE_EN_BIT]; // R3
      next_st.nonfatal_report_en = cfg_wdata[pdl_pkg::CTRL_NONFATAL_EN_BIT]; // R3
    end
    // a message follows the event by one cycle, gated by the enable in force
    next_st.cor_msg = correctable_err_event && st.correctable_report_en; // R2
    next_st.nf_msg = nonfatal_err_event && st.nonfatal_report_en; // R1
  end

  // enables reset to zero so nothing is reported until software opts in
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0; // R3
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;
  assign cfg_rd_valid = st.rd_valid;
  assign err_cor_msg = st.cor_msg;
  assign err_nonfatal_msg = st.nf_msg;

endmodule : pdl_cfg_regs

// file: test/pdl_cfg_regs_asserts.sv
// Purpose: port-level checks on the config register block
// Assumes: one clock; checks wait out the two-flop reset release
// Notes: report enables are tracked here from config writes
`timescale 1ns/1ps
module pdl_cfg_regs_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  // link setup, events and messages
  input wire logic ccc_common,
  input wire logic [2:0] diag_l1_exit_upper_field,
  input wire logic [2:0] diag_l1_exit_lower_field,
  input wire logic aux_power_in,
  input wire logic np_req_issue,
  input wire logic np_req_done,
  input wire logic correctable_err_event,
  input wire logic nonfatal_err_event,
  input wire logic fatal_err_event,
  input wire logic unsupported_req_event,
  input wire logic err_cor_msg,
  input wire logic err_nonfatal_msg
);
  logic [2:0] up_q;
  logic [1:0] en_q;
  logic stat_wr;
  logic ev_any;
  logic [2:0] l1_pick;
  // enables mirror plus settle delay, since the design ignores the bus until reset is synced
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      up_q <= 3'h0;
      en_q <= 2'h0;
    end else begin
      up_q <= {up_q[1:0], 1'h1};
      if (stat_wr && cfg_be[0]) begin
        en_q <= cfg_wdata[1:0];
      end
    end
  end
  // decode helpers
  assign stat_wr = cfg_wr && cfg_addr[11:2] == 10'h01E;
  assign ev_any = correctable_err_event || nonfatal_err_event || fatal_err_event || unsupported_req_event;
  // l1 exit value that the selected clock mode should report
  assign l1_pick = ccc_common ? diag_l1_exit_upper_field : diag_l1_exit_lower_field;
  default clocking @(posedge mclk); endclocking
  default disable iff (!up_q[2]);
  sequence rd_cap;
    cfg_rd && cfg_addr[11:2] == 10'h01F;
  endsequence
  sequence rd_stat;
    cfg_rd && cfg_addr[11:2] == 10'h01E;
  endsequence
  sequence np_issue;
    np_req_issue && !np_req_done;
  endsequence
  sequence w1c_all;
    stat_wr && cfg_be[2] && cfg_wdata[19:16] == 4'hF && !ev_any;
  endsequence
  property flag_after(ev, int b);
    ev ##1 rd_stat |=> cfg_rdata[16 + b];
  endproperty
  chk_nf_msg: assert property (err_nonfatal_msg == ($past(nonfatal_err_event) && $past(en_q[1])))
    else $error("nonfatal message mismatch");
  chk_cor_msg: assert property (err_cor_msg == ($past(correctable_err_event) && $past(en_q[0])))
    else $error("correctable message mismatch");
  chk_stat_rsvd: assert property (rd_stat |=> cfg_rdata[31:22] == 10'h000 && cfg_rdata[1:0] == $past(en_q))
    else $error("status or control read wrong");
  chk_request_outstanding_set: assert property (np_issue ##1 rd_stat |=> cfg_rdata[21])
    else $error("pending bit not set");
  chk_aux_flag: assert property (rd_stat |=> cfg_rdata[20] == $past(aux_power_in, 2))
    else $error("aux power bit wrong");
  chk_ur_flag: assert property (flag_after(unsupported_req_event, 3))
    else $error("unsupported flag not set");
  chk_fatal_flag: assert property (flag_after(fatal_err_event, 2))
    else $error("fatal flag not set");
  chk_nf_flag: assert property (flag_after(nonfatal_err_event, 1))
    else $error("nonfatal flag not set");
  chk_cor_flag: assert property (flag_after(correctable_err_event, 0))
    else $error("correctable flag not set");
  chk_w1c_clear: assert property (w1c_all ##1 !ev_any ##1 rd_stat |=> cfg_rdata[19:16] == 4'h0)
    else $error("flags not cleared");
  chk_cap_fixed: assert property (rd_cap |=> cfg_rdata[31:18] == 14'h0001
    && cfg_rdata[11:0] == 12'hC11)
    else $error("fixed link fields wrong");
  chk_cap_l1: assert property (rd_cap |=> cfg_rdata[17:15] == $past(l1_pick))
    else $error("l1 exit field wrong");
  chk_cap_l0s: assert property (rd_cap |=> cfg_rdata[14:12] == ($past(ccc_common) ? 3'h3 : 3'h4))
    else $error("l0s exit field wrong");
endmodule : pdl_cfg_regs_asserts
bind pdl_cfg_regs pdl_cfg_regs_asserts u_chk (.mclk, .rstn, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
  .cfg_rdata, .ccc_common, .diag_l1_exit_upper_field, .diag_l1_exit_lower_field, .aux_power_in, .np_req_issue,
  .np_req_done, .correctable_err_event, .nonfatal_err_event, .fatal_err_event, .unsupported_req_event,
  .err_cor_msg, .err_nonfatal_msg);

// file: test/pdl_rc_model.sv
// Purpose: upstream partner that completes requests and counts messages
// Assumes: requests arrive as one-cycle pulses
// Notes: slow mode stretches the completion turnaround
`timescale 1ns/1ps
module pdl_rc_model (
  // clock and mode
  input wire logic mclk,
  input wire logic slow,
  // link traffic
  input wire logic np_req_issue,
  input wire logic err_cor_msg,
  input wire logic err_nonfatal_msg,
  output logic np_req_done,
  output int cor_seen,
  output int nf_seen
);
  int owed;
  int wait_c;
  initial np_req_done = 1'h0;
  // one completion at a time; never completes a request it has not seen
  always @(posedge mclk) begin
    np_req_done <= 1'h0;
    cor_seen <= cor_seen + err_cor_msg;
    nf_seen <= nf_seen + err_nonfatal_msg;
    owed = owed + np_req_issue;
    if (owed > 0 && wait_c >= (slow ? 6 : 1)) begin
      np_req_done <= 1'h1;
      owed = owed - 1;
      wait_c = 0;
    end else if (owed > 0) begin
      wait_c = wait_c + 1;
    end
  end
endmodule : pdl_rc_model

// file: test/pdl_cfg_regs_tb.sv
// Purpose: self-checking bench for the config register block
// Assumes: partner model completes requests; inputs change 1 ns after the edge
// Notes: random values come from a fixed seed
`timescale 1ns/1ps
module pdl_cfg_regs_tb;
  logic mclk = 0, rstn = 0, cfg_rd = 0, cfg_wr = 0, ccc_common = 0, aux_power_in = 0, np_req_issue = 0, slow = 0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0, ev = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [2:0] diag_l1_exit_upper_field = 3'h0, diag_l1_exit_lower_field = 3'h0;
  logic cfg_rd_valid, np_req_done, err_cor_msg, err_nonfatal_msg;
  int fail_count = 0, total_checks = 0, cor_seen, nf_seen;
  pdl_cfg_regs dut (.mclk, .rstn, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_valid,
    .ccc_common, .diag_l1_exit_upper_field, .diag_l1_exit_lower_field, .aux_power_in, .np_req_issue,
    .np_req_done, .correctable_err_event(ev[0]), .nonfatal_err_event(ev[1]), .fatal_err_event(ev[2]),
    .unsupported_req_event(ev[3]), .err_cor_msg, .err_nonfatal_msg);
  pdl_rc_model rc (.mclk, .slow, .np_req_issue, .err_cor_msg, .err_nonfatal_msg, .np_req_done, .cor_seen,
    .nf_seen);
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // every bus task ends a cycle idle so strobes never toggle twice in one step
  task automatic wr(logic [11:0] a, logic [3:0] b, logic [31:0] d);
    cfg_wr = 1'h1;
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    tick();
    cfg_wr = 1'h0;
    tick();
  endtask : wr
  task automatic rd(logic [11:0] a, output logic [31:0] d);
    cfg_rd = 1'h1;
    cfg_addr = a;
    tick();
    cfg_rd = 1'h0;
    check("read valid", 1'h1, cfg_rd_valid);
    d = cfg_rdata;
    tick();
  endtask : rd
  // no idle tail, so a read may follow in the very next cycle
  task automatic pulse(logic [3:0] m, logic i);
    ev = m;
    np_req_issue = i;
    tick();
    ev = 4'h0;
    np_req_issue = 1'h0;
  endtask : pulse
  function automatic logic [31:0] cap_exp(logic c, logic [2:0] u, logic [2:0] l);
    return 32'h0004_0C11 | {14'h0, c ? u : l, c ? 3'h3 : 3'h4, 12'h000};
  endfunction : cap_exp
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (4000) @(posedge mclk);
    fail_count++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] x;
    logic [1:0] e;
    logic [3:0] m;
    logic [3:0] k;
    int c0;
    int n0;
    void'($urandom(73128));
    repeat (5) @(posedge mclk);
    #1 rstn = 1'h1;
    repeat (3) tick();
    rd(12'h078, d);
    check("reset word", 32'h0, d);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      ccc_common = i[0];
      diag_l1_exit_upper_field = 3'($urandom);
      diag_l1_exit_lower_field = 3'($urandom);
      wr(12'h07C, 4'hF, $urandom);
      rd(12'h07C, d);
      x = cap_exp(ccc_common, diag_l1_exit_upper_field, diag_l1_exit_lower_field);
      check("link caps", x, d);
    end
    $display("test link caps done");
    for (int i = 0; i < 8; i++) begin
      e = (i < 4) ? i[1:0] : 2'($urandom);
      wr(12'h078, 4'h1, {30'($urandom), e});
      rd(12'h078, d);
      check("control", {14'h0, e}, d[15:0]);
      c0 = cor_seen;
      n0 = nf_seen;
      pulse(4'h3, 1'h0);
      repeat (2) tick();
      check("cor msgs", c0 + e[0], cor_seen);
      check("nf msgs", n0 + e[1], nf_seen);
    end
    $display("test messages done");
    wr(12'h078, 4'h4, 32'h000F_0000);
    rd(12'h078, d);
    check("flags clear", 4'h0, d[19:16]);
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 4'hC : 4'($urandom);
      pulse(m, 1'h0);
      rd(12'h078, d);
      check("flags", m, d[19:16]);
      k = (i == 0) ? 4'h0 : 4'($urandom);
      wr(12'h078, 4'h4, {12'h0, k, 16'h0});
      rd(12'h078, d);
      check("flags w1c", m & ~k, d[19:16]);
      wr(12'h078, 4'h4, 32'h000F_0000);
    end
    // an event on the clear cycle must survive the clear
    cfg_addr = 12'h078;
    cfg_be = 4'h4;
    cfg_wdata = 32'h000F_0000;
    cfg_wr = 1'h1;
    pulse(4'h5, 1'h0);
    cfg_wr = 1'h0;
    rd(12'h078, d);
    check("set wins", 4'h5, d[19:16]);
    wr(12'h078, 4'h4, 32'h000F_0000);
    $display("test flags done");
    aux_power_in = 1'h1;
    slow = 1'h1;
    pulse(4'h0, 1'h1);
    rd(12'h078, d);
    check("pending aux", 2'h3, d[21:20]);
    aux_power_in = 1'h0;
    repeat (10) tick();
    rd(12'h078, d);
    check("drained", 2'h0, d[21:20]);
    // fast partner: second issue lands on the first completion's cycle
    slow = 1'h0;
    pulse(4'h0, 1'h1);
    tick();
    pulse(4'h0, 1'h1);
    rd(12'h078, d);
    check("pending fast", 1'h1, d[21]);
    repeat (4) tick();
    rd(12'h078, d);
    check("drained fast", 1'h0, d[21]);
    rd(12'h100, d);
    check("unmapped", 32'h0, d);
    $display("test pending done");
    // mid-run reset must drop enables and flags
    wr(12'h078, 4'h1, 32'h0000_0003);
    pulse(4'hF, 1'h0);
    rstn = 1'h0;
    repeat (2) tick();
    rstn = 1'h1;
    repeat (3) tick();
    rd(12'h078, d);
    check("reset again", 32'h0, d);
    $display("test mid reset done");
    test_done();
  end
endmodule : pdl_cfg_regs_tb
